// >>> cursor_layer.sv
/*
  One cursor layer laid over the pixel below it: palette lookup, inversion,
  transparency or alpha blend.
  Assumes hit, data and below refer to the same pixel; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mixer_params.svh"

module cursor_layer
  import mixer_pkg::*;
(
  // cursor state
  input  wire logic            active,
  input  wire logic [1:0]      mode,
  input  wire logic            popup,
  input  wire logic [3:0][23:0] pal,
  input  wire logic [31:0]     data,
  // pixel beneath
  input  wire logic [23:0]     below,
  input  wire logic            belowYuv,
  // result
  output logic      [23:0]     pixOut,
  output logic                 mismatch
);
  wire [1:0] idx = data[1:0];
  wire [1:0] effMode = popup ? CUR_INDEX4 : mode;

  always_comb begin
    pixOut   = below;
    mismatch = 1'b0;
    if (active) begin
      case (effMode)
        CUR_LEGACY: begin
          case (idx)
            2'h0:    pixOut = pal[0];
            2'h1:    pixOut = pal[1];
            2'h2:    pixOut = below;
            default: pixOut = ~below;
          endcase
        end
        CUR_INDEX4: pixOut = pal[idx];
        CUR_ARGB: begin
          if (belowYuv) begin
            pixOut   = data[23:0];
            mismatch = 1'b1;
          end else begin
            pixOut = mix24(data[31:24], data[23:0], below);
          end
        end
        default: pixOut = below;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> cursor_overlay_plane_mixer.sv
/*
  Plane mixer for two display pipes: two hardware cursors, either usable as a
  popup icon, and one routable overlay plane, programmed over AHB-Lite.
  Assumes pipe pixels, fetched cursor words and fetched overlay pixels arrive
  aligned in the same mclk cycle; one output pixel per pipe a cycle later.
*/
// Function
// - two independent cursor planes, each can feed a display pipe
// - a cursor covers a 64 by 64 pixel square
// - the cursor is composited above every other plane
// - legacy cursor mode can invert the pixel beneath
// - true-colour cursor pixels are alpha blended in blend mode
// - each cursor can be moved between pipes while both run
// - two-bit cursor index looks up a four-entry palette
// - index picks transparent, invert, or one of two colours
// - blending only joins planes of the same colour format
// - popup icon sits just below the cursor, above the rest
// - outside VGA modes either cursor may act as popup icon
// - popup data is two-bit indexed through the cursor palette
// - one overlay plane, routed primary, secondary or bypass
// - overlay shows on the primary display by default
// - destination key matches 8 or 15 bit colour, or alpha blends
// - source key makes matching overlay pixels transparent
// - overlay has its own gamma correction
// - YUV to RGB conversion can be bypassed for RGB data
// - colour control acts on overlay data only while in YUV
// - interlaced overlay supports weave and bob
`timescale 1ns/100ps
`default_nettype none
`include "mixer_params.svh"

module cursor_overlay_plane_mixer
  import mixer_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // display pipe streams
  input  wire logic [1:0]       pipeValid,
  input  wire logic [1:0][11:0] pipeX,
  input  wire logic [1:0][11:0] pipeY,
  input  wire logic [1:0][31:0] pipeGfx,
  input  wire logic [1:0]       pipeYuv,
  // fetched cursor words
  input  wire logic [1:0][31:0] curData,
  // fetched overlay pixels
  input  wire logic             ovlValid,
  input  wire logic [23:0]      ovlPix,
  input  wire logic [23:0]      ovlPixNext,
  input  wire logic [23:0]      ovlPixPrev,
  input  wire logic             ovlField,
  // mixed pipe outputs
  output logic      [1:0]       outValid,
  output logic      [1:0][23:0] outPix,
  // overlay bypass output
  output logic                  bypValid,
  output logic      [23:0]      bypPix
);

  // registers
  logic [11:0]           ctrl_r;
  logic [1:0][4:0]       curCtrl_r;
  logic [1:0][11:0]      curX_r;
  logic [1:0][11:0]      curY_r;
  logic [1:0][3:0][23:0] curPal_r;
  logic [11:0]           ovlX_r;
  logic [11:0]           ovlY_r;
  logic [11:0]           ovlW_r;
  logic [11:0]           ovlH_r;
  logic [23:0]           dkey_r;
  logic [23:0]           skey_r;
  logic [23:0]           smask_r;
  logic [25:0]           color_r;
  logic [7:0]            gIdx_r;
  logic                  sticky_r;
  logic [31:0]           hrdata_r;

  // bus slave state
  bus_state_e            state_r;
  bus_state_e            state_nxt;
  logic [7:0]            wAddr_r;

  // ---------------- ahb-lite slave ----------------

  wire        addrOk = hsel & htrans[1] & hready;
  wire        wrOk   = hwrite & (hsize == `HSIZE_WORD);
  wire [7:0]  rA     = haddr[7:0];
  wire        wrEn   = (state_r == BUS_WR);

  assign state_nxt = !addrOk ? BUS_IDLE : (wrOk ? BUS_WR : (hwrite ? BUS_IDLE : BUS_RD));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= BUS_IDLE;
      wAddr_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (addrOk) wAddr_r <= rA;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // write strobes
  wire wCtrl  = wrEn & (wAddr_r == `OFS_CTRL);
  wire wSts   = wrEn & (wAddr_r == `OFS_STATUS);
  wire wCaCtl = wrEn & (wAddr_r == `OFS_CURA_CTL);
  wire wCaPos = wrEn & (wAddr_r == `OFS_CURA_POS);
  wire wCbCtl = wrEn & (wAddr_r == `OFS_CURB_CTL);
  wire wCbPos = wrEn & (wAddr_r == `OFS_CURB_POS);
  wire wPal   = wrEn & (wAddr_r[7:5] == `PAL_PAGE);
  wire wOPos  = wrEn & (wAddr_r == `OFS_OVL_POS);
  wire wOSize = wrEn & (wAddr_r == `OFS_OVL_SIZE);
  wire wDkey  = wrEn & (wAddr_r == `OFS_DKEY);
  wire wSkey  = wrEn & (wAddr_r == `OFS_SKEY);
  wire wSmask = wrEn & (wAddr_r == `OFS_SMASK);
  wire wColor = wrEn & (wAddr_r == `OFS_COLOR);
  wire wGIdx  = wrEn & (wAddr_r == `OFS_GIDX);
  wire wGData = wrEn & (wAddr_r == `OFS_GDATA);

  // live state and status
  logic [1:0] mis;
  wire        misAny     = |mis;
  wire [31:0] statusWord = {30'h0, ovlField, sticky_r};

  // read selection
  wire [31:0] rdMux =
    (rA == `OFS_CTRL)      ? {20'h0, ctrl_r} :
    (rA == `OFS_STATUS)    ? statusWord :
    (rA == `OFS_CURA_CTL)  ? {27'h0, curCtrl_r[0]} :
    (rA == `OFS_CURA_POS)  ? {4'h0, curY_r[0], 4'h0, curX_r[0]} :
    (rA == `OFS_CURB_CTL)  ? {27'h0, curCtrl_r[1]} :
    (rA == `OFS_CURB_POS)  ? {4'h0, curY_r[1], 4'h0, curX_r[1]} :
    (rA[7:5] == `PAL_PAGE) ? {8'h00, curPal_r[rA[4]][rA[3:2]]} :
    (rA == `OFS_OVL_POS)   ? {4'h0, ovlY_r, 4'h0, ovlX_r} :
    (rA == `OFS_OVL_SIZE)  ? {4'h0, ovlH_r, 4'h0, ovlW_r} :
    (rA == `OFS_DKEY)      ? {8'h00, dkey_r} :
    (rA == `OFS_SKEY)      ? {8'h00, skey_r} :
    (rA == `OFS_SMASK)     ? {8'h00, smask_r} :
    (rA == `OFS_COLOR)     ? {6'h00, color_r} :
    (rA == `OFS_GIDX)      ? {24'h0, gIdx_r} :
    32'h0;

  always_ff @(posedge mclk) begin
    if (sys_rst) hrdata_r <= 32'h0;
    else if (addrOk & ~hwrite) hrdata_r <= rdMux;
  end

  // control and overlay registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r  <= `CTRL_RST;
      ovlX_r  <= 12'h000;
      ovlY_r  <= 12'h000;
      ovlW_r  <= 12'h000;
      ovlH_r  <= 12'h000;
      dkey_r  <= 24'h000000;
      skey_r  <= 24'h000000;
      smask_r <= 24'h000000;
      color_r <= `COLOR_RST;
    end else begin
      if (wCtrl) ctrl_r <= hwdata[11:0];
      if (wOPos) begin
        ovlX_r <= hwdata[`POS_X];
        ovlY_r <= hwdata[`POS_Y];
      end
      if (wOSize) begin
        ovlW_r <= hwdata[`POS_X];
        ovlH_r <= hwdata[`POS_Y];
      end
      if (wDkey) dkey_r <= hwdata[23:0];
      if (wSkey) skey_r <= hwdata[23:0];
      if (wSmask) smask_r <= hwdata[23:0];
      if (wColor) color_r <= hwdata[25:0];
    end
  end

  // gamma index auto-increments on each data write
  always_ff @(posedge mclk) begin
    if (sys_rst) gIdx_r <= 8'h00;
    else if (wGIdx) gIdx_r <= hwdata[7:0];
    else if (wGData) gIdx_r <= gIdx_r + 8'h01;
  end

  // mismatch flag: write one to clear, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) sticky_r <= 1'b0;
    else sticky_r <= (sticky_r & ~(wSts & hwdata[`STS_MIS])) | misAny;
  end

  // cursor registers, one set per cursor
  for (genvar c = 0; c < 2; c++) begin : g_creg
    wire wCtl = c ? wCbCtl : wCaCtl;
    wire wPos = c ? wCbPos : wCaPos;
    wire wP   = wPal & (wAddr_r[4] == 1'(c));

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        curCtrl_r[c] <= `CUR_RST;
        curX_r[c]    <= 12'h000;
        curY_r[c]    <= 12'h000;
        curPal_r[c]  <= '0;
      end else begin
        if (wCtl) curCtrl_r[c] <= hwdata[4:0];
        if (wPos) begin
          curX_r[c] <= hwdata[`POS_X];
          curY_r[c] <= hwdata[`POS_Y];
        end
        if (wP) curPal_r[c][wAddr_r[3:2]] <= hwdata[23:0];
      end
    end
  end

  // ---------------- overlay plane ----------------

  wire ovl_route_e  route     = ovl_route_e'(ctrl_r[`CTL_ROUTE]);
  wire dkey_mode_e  dkMode    = dkey_mode_e'(ctrl_r[`CTL_DKEY]);
  wire deint_mode_e deMode    = deint_mode_e'(ctrl_r[`CTL_DEINT]);

  // secondary is the pipe that is not primary; bypass shows on neither pipe, any other code shows on primary
  wire        routePipe = (route == ROUTE_SEC) ? ~ctrl_r[`CTL_PRIM] : ctrl_r[`CTL_PRIM];
  wire [1:0]  ovlOnPipe = (route == ROUTE_BYP) ? 2'h0 : (routePipe ? 2'h2 : 2'h1);

  // lines of the opposite field are filled from the previous field or interpolated
  wire        missing  = pipeY[routePipe][0] ^ ovlField;
  wire [23:0] deintPix =
    (missing & (deMode == DEINT_WEAVE)) ? ovlPixPrev :
    (missing & (deMode == DEINT_BOB))   ? avg24(ovlPix, ovlPixNext) :
    ovlPix;

  wire        srcKeyed = ctrl_r[`CTL_SKEY] & (((deintPix ^ skey_r) & smask_r) == 24'h000000);

  logic [23:0] ovlRgb;

  overlay_color u_color (
    .mclk    (mclk),
    .yuvSrc  (ctrl_r[`CTL_YUV]),
    .ccEn    (ctrl_r[`CTL_CC] & ctrl_r[`CTL_YUV]),
    .color   (color_r),
    .gammaEn (ctrl_r[`CTL_GAMMA]),
    .gWr     (wGData),
    .gIdx    (gIdx_r),
    .gData   (hwdata[7:0]),
    .pixIn   (deintPix),
    .rgbOut  (ovlRgb)
  );

  // bypass stream leaves unmixed
  logic        bypValid_r;
  logic [23:0] bypPix_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bypValid_r <= 1'b0;
      bypPix_r   <= 24'h000000;
    end else begin
      bypValid_r <= (route == ROUTE_BYP) & ovlValid;
      bypPix_r   <= ovlRgb;
    end
  end

  assign bypValid = bypValid_r;
  assign bypPix   = bypPix_r;

  // ---------------- cursor roles ----------------

  // popup role only outside VGA modes
  wire [1:0] effPop = {curCtrl_r[1][`CC_POP], curCtrl_r[0][`CC_POP]} & {2{~ctrl_r[`CTL_VGA]}};

  // popup cursor is the lower layer; with no popup, cursor B sits under A
  wire       lowSel = ~effPop[0];
  wire       topSel = ~lowSel;

  // ---------------- per-pipe mixing ----------------

  for (genvar p = 0; p < 2; p++) begin : g_pipe
    logic [1:0]  hit;
    logic [23:0] lowPix;
    logic [23:0] topPix;
    logic        lowMis;
    logic        topMis;
    logic        valid_r;
    logic [23:0] pix_r;

    for (genvar c = 0; c < 2; c++) begin : g_cur
      wire [11:0] dx = pipeX[p] - curX_r[c];
      wire [11:0] dy = pipeY[p] - curY_r[c];
      // pipe selection is sampled every pixel, so a move lands on the next pixel
      assign hit[c] = pipeValid[p] & curCtrl_r[c][`CC_EN]
                    & (curCtrl_r[c][`CC_PIPE] == 1'(p))
                    & (dx < `CUR_SIZE) & (dy < `CUR_SIZE);
    end

    // overlay window and keying
    wire [11:0] ox      = pipeX[p] - ovlX_r;
    wire [11:0] oy      = pipeY[p] - ovlY_r;
    wire        ovlHere = ovlOnPipe[p] & ovlValid & pipeValid[p] & (ox < ovlW_r) & (oy < ovlH_r);
    wire [23:0] gfx     = pipeGfx[p][23:0];
    wire        key8    = (gfx[7:0] == dkey_r[7:0]);
    wire        key15   = ({gfx[23:19], gfx[15:11], gfx[7:3]} == dkey_r[14:0]);
    wire        dstPass = (dkMode == DKEY_8) ? key8 : (dkMode == DKEY_15) ? key15 : 1'b1;
    wire        alpha   = (dkMode == DKEY_ALPHA);
    wire        ovlMis  = ovlHere & alpha & pipeYuv[p];

    wire [23:0] ovlMix =
      (~ovlHere | srcKeyed | ~dstPass)  ? gfx :
      (alpha & ~pipeYuv[p])             ? mix24(pipeGfx[p][31:24], gfx, ovlRgb) :
      ovlRgb;

    // popup layer above overlay and graphics
    cursor_layer u_low (
      .active   (hit[lowSel]),
      .mode     (curCtrl_r[lowSel][`CC_MODE]),
      .popup    (effPop[lowSel]),
      .pal      (curPal_r[lowSel]),
      .data     (curData[lowSel]),
      .below    (ovlMix),
      .belowYuv (pipeYuv[p]),
      .pixOut   (lowPix),
      .mismatch (lowMis)
    );

    // cursor layer always last, so it is topmost
    cursor_layer u_top (
      .active   (hit[topSel]),
      .mode     (curCtrl_r[topSel][`CC_MODE]),
      .popup    (effPop[topSel]),
      .pal      (curPal_r[topSel]),
      .data     (curData[topSel]),
      .below    (lowPix),
      .belowYuv (pipeYuv[p]),
      .pixOut   (topPix),
      .mismatch (topMis)
    );

    assign mis[p] = lowMis | topMis | ovlMis;

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        valid_r <= 1'b0;
        pix_r   <= 24'h000000;
      end else begin
        valid_r <= pipeValid[p];
        pix_r   <= topPix;
      end
    end

    assign outValid[p] = valid_r;
    assign outPix[p]   = pix_r;
  end

endmodule
`default_nettype wire

// >>> cursor_overlay_plane_mixer_test.sv
/*
  Self-checking bench: register access, overlay routing, keying, de-interlace, cursors.
  Assumes mixer_pkg, mixer_params.svh, pipe_sink and the checker compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mixer_params.svh"
module cursor_overlay_plane_mixer_test
  import mixer_pkg::*;
;
  localparam logic [23:0] OV = 24'hA0B0C0;
  localparam logic [31:0] G  = 32'h00123456;
  localparam logic [23:0] GP = 24'h123456;
  localparam logic [23:0] P0 = 24'h112233;
  logic                  mclk, sys_rst, hsel, hwrite, ovlValid, ovlField;
  logic [31:0]           haddr, hwdata, rdv;
  logic [1:0]            htrans, pipeValid, pipeYuv, yuvSel;
  logic [2:0]            hsize;
  logic [1:0][11:0]      pipeX, pipeY;
  logic [1:0][31:0]      pipeGfx, curData;
  logic [23:0]           ovlPix, ovlPixNext, ovlPixPrev;
  logic [23:0]           exp4 [4];
  wire logic             hreadyout, hresp, bypValid;
  wire logic [31:0]      hrdata;
  wire logic [1:0]       outValid;
  wire logic [1:0][23:0] outPix, lastPix;
  wire logic [23:0]      bypPix, lastByp;
  int                    nErrors, cmpCount;
  cursor_overlay_plane_mixer cursor_overlay_plane_mixer_i (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pipeValid, .pipeX, .pipeY, .pipeGfx,
    .pipeYuv, .curData, .ovlValid, .ovlPix, .ovlPixNext, .ovlPixPrev, .ovlField, .outValid, .outPix,
    .bypValid, .bypPix);
  pipe_sink pipe_sink_i (.mclk, .outValid, .outPix, .bypValid, .bypPix, .lastPix, .lastByp);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task tally_and_finish;
    if (nErrors == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chkPix(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %0t pixel %h expected %h", $time, got, exp);
    end
  endtask
  task chkReg(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %0t register %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chkReg(rdv, e);
  endtask
  // one pixel on both pipes, then both results
  task px(input logic [11:0] x, input logic [11:0] y, input logic [31:0] g, input logic [31:0] ca,
          input logic [31:0] cb, input logic [23:0] ea, input logic [23:0] eb);
    @(posedge mclk);
    pipeValid <= 2'b11;
    pipeYuv <= yuvSel;
    pipeX <= {x, x};
    pipeY <= {y, y};
    pipeGfx <= {g, g};
    curData <= {cb, ca};
    @(posedge mclk);
    #1;
    chkPix(outPix[0], ea);
    chkPix(outPix[1], eb);
  endtask
  initial begin
    #50000;
    nErrors++;
    tally_and_finish;
  end
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, pipeValid, pipeYuv, yuvSel, pipeX, pipeY, pipeGfx, curData} = '0;
    {sys_rst, ovlValid, ovlField, hsize} = {1'b1, 1'b1, 1'b0, `HSIZE_WORD};
    {ovlPix, ovlPixNext, ovlPixPrev} = {OV, 24'h203040, 24'h506070};
    {nErrors, cmpCount} = '0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(`OFS_CTRL, 32'h00000000);
    rc(`OFS_COLOR, 32'h00808000);
    rc(8'h80, 32'h00000000);
    wr(`OFS_OVL_SIZE, 32'h00100010);
    px(12'd1, 12'd1, G, 0, 0, OV, GP);
    wr(`OFS_CTRL, 32'h1);
    px(12'd1, 12'd1, G, 0, 0, GP, OV);
    wr(`OFS_CTRL, 32'h2);
    px(12'd1, 12'd1, G, 0, 0, GP, GP);
    wr(`OFS_CTRL, 32'h3);
    chkPix(lastByp, OV);
    px(12'd1, 12'd1, G, 0, 0, OV, GP);
    wr(`OFS_DKEY, 32'h56);
    wr(`OFS_CTRL, 32'h40);
    px(12'd1, 12'd1, G, 0, 0, OV, GP);
    px(12'd1, 12'd1, G ^ 32'h1, 0, 0, GP ^ 24'h1, GP ^ 24'h1);
    wr(`OFS_SKEY, {8'h00, OV});
    wr(`OFS_SMASK, 32'h00FFFFFF);
    wr(`OFS_CTRL, 32'h100);
    px(12'd1, 12'd1, G, 0, 0, GP, GP);
    wr(`OFS_CTRL, 32'h10);
    px(12'd1, 12'd1, G, 0, 0, 24'h506070, GP);
    px(12'd1, 12'd2, G, 0, 0, OV, GP);
    wr(`OFS_CTRL, 32'h20);
    px(12'd1, 12'd1, G, 0, 0, 24'h607080, GP);
    wr(`OFS_CTRL, 32'h0);
    wr(8'h20, {8'h00, P0});
    wr(8'h24, 32'h445566);
    wr(`OFS_CURA_POS, 32'h00640064);
    wr(`OFS_CURA_CTL, 32'h1);
    exp4 = '{P0, 24'h445566, GP, ~GP};
    for (int i = 0; i < 4; i++) px(12'd100, 12'd100, G, 32'(i), 0, exp4[i], GP);
    px(12'd163, 12'd163, G, 0, 0, P0, GP);
    px(12'd164, 12'd100, G, 0, 0, GP, GP);
    px(12'd100, 12'd164, G, 0, 0, GP, GP);
    wr(8'h28, 32'h778899);
    wr(8'h2C, 32'hAABBCC);
    wr(`OFS_CURA_CTL, 32'h5);
    exp4 = '{P0, 24'h445566, 24'h778899, 24'hAABBCC};
    for (int i = 0; i < 4; i++) px(12'd100, 12'd100, G, 32'(i), 0, exp4[i], GP);
    wr(`OFS_CURA_POS, 32'h0);
    px(12'd1, 12'd1, G, 3, 0, 24'hAABBCC, GP);
    wr(`OFS_CURA_POS, 32'h00640064);
    wr(`OFS_CURA_CTL, 32'h9);
    // 128*255 >> 8 per channel over black
    px(12'd100, 12'd100, 0, 32'h80FFFFFF, 0, 24'h7F7F7F, 0);
    yuvSel = 2'b01;
    px(12'd100, 12'd100, 0, 32'h80FFFFFF, 0, 24'hFFFFFF, 0);
    yuvSel = 2'b00;
    px(12'd100, 12'd100, 0, 32'h80FFFFFF, 0, 24'h7F7F7F, 0);
    rc(`OFS_STATUS, 32'h1);
    wr(`OFS_STATUS, 32'h1);
    rc(`OFS_STATUS, 32'h0);
    wr(`OFS_CURA_CTL, 32'h3);
    px(12'd100, 12'd100, G, 0, 0, GP, P0);
    @(posedge mclk);
    #1;
    chkPix(lastPix[1], P0);
    wr(`OFS_CURA_CTL, 32'h1);
    wr(8'h38, 32'h0000AA);
    wr(`OFS_CURB_POS, 32'h00640064);
    wr(`OFS_CURB_CTL, 32'h19);
    px(12'd100, 12'd100, G, 2, 2, 24'h0000AA, GP);
    px(12'd100, 12'd100, G, 0, 2, P0, GP);
    wr(`OFS_CTRL, 32'h4);
    px(12'd1, 12'd1, G, 0, 0, 24'hF962F5, GP);
    wr(`OFS_COLOR, 32'h01808000);
    wr(`OFS_CTRL, 32'hC);
    px(12'd1, 12'd1, G, 0, 0, 24'hE3942E, GP);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// >>> mixer_monitor.sv
/*
  Checker of the mixer's top ports: bus answer, pixel latency, bypass output.
  Assumes it is bound to cursor_overlay_plane_mixer; one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module mixer_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // pixels
  input wire logic [1:0]  pipeValid,
  input wire logic        ovlValid,
  input wire logic [1:0]  outValid,
  input wire logic        bypValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic rdTaken;
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_valid_a; pipeValid[0] |=> outValid[0]; endproperty
  a_valid_a: assert property (p_valid_a) else $error("pipe a pixel lost");
  property p_valid_b; outValid[1] |-> $past(pipeValid[1]); endproperty
  a_valid_b: assert property (p_valid_b) else $error("pipe b pixel out of nothing");
  property p_idle; pipeValid == 2'b00 |=> outValid == 2'b00; endproperty
  a_idle: assert property (p_idle) else $error("pixel out while pipes idle");
  property p_byp_src; bypValid |-> $past(ovlValid); endproperty
  a_byp_src: assert property (p_byp_src) else $error("bypass pixel without overlay pixel");
  property p_byp_default; $fell(sys_rst) |-> !bypValid ##1 !bypValid; endproperty
  a_byp_default: assert property (p_byp_default) else $error("overlay left primary after reset");
  property p_out_clear; $fell(sys_rst) |-> outValid == 2'b00; endproperty
  a_out_clear: assert property (p_out_clear) else $error("pixel valid straight out of reset");
  property p_rd_hold; !rdTaken |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
endmodule
bind cursor_overlay_plane_mixer mixer_monitor mixer_monitor_i (.mclk, .sys_rst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .pipeValid, .ovlValid, .outValid, .bypValid);
`default_nettype wire

// >>> mixer_params.svh
/*
  Constants for the cursor and overlay plane mixer: register byte offsets,
  field positions, reset values and arithmetic constants.
  Assumes inclusion by its bare name from every design file that needs it.
*/
`ifndef MIXER_PARAMS_SVH
`define MIXER_PARAMS_SVH

// register byte offsets (low address byte)
`define OFS_CTRL     8'h00
`define OFS_STATUS   8'h04
`define OFS_CURA_CTL 8'h08
`define OFS_CURA_POS 8'h0C
`define OFS_CURB_CTL 8'h10
`define OFS_CURB_POS 8'h14
`define PAL_PAGE     3'h1
`define OFS_OVL_POS  8'h40
`define OFS_OVL_SIZE 8'h44
`define OFS_DKEY     8'h48
`define OFS_SKEY     8'h4C
`define OFS_SMASK    8'h50
`define OFS_COLOR    8'h54
`define OFS_GIDX     8'h58
`define OFS_GDATA    8'h5C

// control register fields
`define CTL_ROUTE 1:0
`define CTL_YUV   2
`define CTL_CC    3
`define CTL_DEINT 5:4
`define CTL_DKEY  7:6
`define CTL_SKEY  8
`define CTL_GAMMA 9
`define CTL_VGA   10
`define CTL_PRIM  11
`define CTRL_RST  12'h000

// cursor control fields
`define CC_EN     0
`define CC_PIPE   1
`define CC_MODE   3:2
`define CC_POP    4
`define CUR_RST   5'h00

// position and colour fields
`define POS_X     11:0
`define POS_Y     27:16
`define COL_BRI   7:0
`define COL_CON   15:8
`define COL_SAT   23:16
`define COL_HUE   25:24
`define COLOR_RST 26'h0808000

// status fields
`define STS_MIS   0
`define STS_FLD   1

// geometry, bus and arithmetic constants
`define CUR_SIZE   12'h040
`define HSIZE_WORD 3'h2
`define CC_SHIFT   7
`define CSC_SHIFT  8
`define UV_MID     18'sh00080
`define CSC_RV     18'sh00167
`define CSC_GU     18'sh00058
`define CSC_GV     18'sh000B7
`define CSC_BU     18'sh001C6

`endif

// >>> mixer_pkg.sv
/*
  Types and small pixel functions shared by the mixer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mixer_pkg;
  typedef enum logic [1:0] {BUS_IDLE = 2'h0, BUS_WR = 2'h1, BUS_RD = 2'h2} bus_state_e;
  typedef enum logic [1:0] {CUR_LEGACY = 2'h0, CUR_INDEX4 = 2'h1, CUR_ARGB = 2'h2} cur_mode_e;
  typedef enum logic [1:0] {ROUTE_PRI = 2'h0, ROUTE_SEC = 2'h1, ROUTE_BYP = 2'h2} ovl_route_e;
  typedef enum logic [1:0] {DKEY_OFF = 2'h0, DKEY_8 = 2'h1, DKEY_15 = 2'h2, DKEY_ALPHA = 2'h3} dkey_mode_e;
  typedef enum logic [1:0] {DEINT_OFF = 2'h0, DEINT_WEAVE = 2'h1, DEINT_BOB = 2'h2} deint_mode_e;

  function automatic logic [23:0] mix24(input logic [7:0] a, input logic [23:0] fg, input logic [23:0] bg);
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      r[i*8 +: 8] = 8'((16'(a) * 16'(fg[i*8 +: 8]) + 16'(8'hFF - a) * 16'(bg[i*8 +: 8])) >> 8);
    end
    return r;
  endfunction

  function automatic logic [23:0] avg24(input logic [23:0] x, input logic [23:0] y);
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      r[i*8 +: 8] = 8'((9'(x[i*8 +: 8]) + 9'(y[i*8 +: 8])) >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] clamp8(input logic signed [17:0] v);
    return (v < 18'sh00000) ? 8'h00 : (v > 18'sh000FF) ? 8'hFF : v[7:0];
  endfunction
endpackage

// >>> overlay_color.sv
/*
  Overlay colour path: colour control, YUV to RGB conversion with bypass,
  and its own gamma table.
  Assumes the gamma table is loaded by software before gamma is enabled.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mixer_params.svh"

module overlay_color
  import mixer_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // controls
  input  wire logic        yuvSrc,
  input  wire logic        ccEn,
  input  wire logic [25:0] color,
  input  wire logic        gammaEn,
  // gamma table load
  input  wire logic        gWr,
  input  wire logic [7:0]  gIdx,
  input  wire logic [7:0]  gData,
  // pixel
  input  wire logic [23:0] pixIn,
  output logic      [23:0] rgbOut
);
  logic [7:0] lut [256];
  logic signed [17:0] yA, uC, vC, uS, vS, uH, vH, yF;
  logic [23:0] rgb;

  always_ff @(posedge mclk) begin
    if (gWr) lut[gIdx] <= gData;
  end

  always_comb begin
    yA = (($signed({10'h000, pixIn[23:16]}) * $signed({10'h000, color[`COL_CON]})) >>> `CC_SHIFT)
         + 18'($signed(color[`COL_BRI]));
    uC = $signed({10'h000, pixIn[15:8]}) - `UV_MID;
    vC = $signed({10'h000, pixIn[7:0]}) - `UV_MID;
    uS = (uC * $signed({10'h000, color[`COL_SAT]})) >>> `CC_SHIFT;
    vS = (vC * $signed({10'h000, color[`COL_SAT]})) >>> `CC_SHIFT;
    if (!ccEn) begin
      yA = $signed({10'h000, pixIn[23:16]});
      uS = uC;
      vS = vC;
    end
    case (ccEn ? color[`COL_HUE] : 2'h0)
      2'h0:    begin uH = uS;  vH = vS;  end
      2'h1:    begin uH = -vS; vH = uS;  end
      2'h2:    begin uH = -uS; vH = -vS; end
      default: begin uH = vS;  vH = -uS; end
    endcase
    yF  = $signed({10'h000, clamp8(yA)});
    rgb = {clamp8(yF + ((`CSC_RV * vH) >>> `CSC_SHIFT)),
           clamp8(yF - ((`CSC_GU * uH + `CSC_GV * vH) >>> `CSC_SHIFT)),
           clamp8(yF + ((`CSC_BU * uH) >>> `CSC_SHIFT))};
    if (!yuvSrc) rgb = pixIn;
  end

  assign rgbOut = gammaEn ? {lut[rgb[23:16]], lut[rgb[15:8]], lut[rgb[7:0]]} : rgb;
endmodule
`default_nettype wire

// >>> pipe_sink.sv
/*
  Model of the display pipes' blenders: keeps the last pixel each took.
  Assumes the mixer's outputs are valid for one cycle per pixel.
*/
`timescale 1ns/100ps
`default_nettype none
module pipe_sink (
  // clock
  input wire logic             mclk,
  // mixer outputs
  input wire logic [1:0]       outValid,
  input wire logic [1:0][23:0] outPix,
  input wire logic             bypValid,
  input wire logic [23:0]      bypPix,
  // captured pixels
  output logic     [1:0][23:0] lastPix,
  output logic     [23:0]      lastByp
);
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (outValid[p]) begin
        lastPix[p] <= outPix[p];
      end
    end
    if (bypValid) begin
      lastByp <= bypPix;
    end
  end
endmodule
`default_nettype wire
